// ### rtl/usb_global_irq_status.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns

// What this block does
// - device mode, enable bit 7 gates frame-received, bit 6 NAK-received interrupt.
// - enable bit 4 gates overflow, bit 3 host frame timing; bit 5 reads zero.
// - enable bit 2 gates suspend/wakeup, bit 1 transfer done; enables reset to zero.
// - enable bit 0 gates attach/detach in host mode, bus reset in device mode.
// - address register holds 7-bit address plus free user flag, all read/write.
// - host mode, status bits 7/6 show frame pending and frame being sent.
// - status bit 5 shows engine idle, mirrored at flag bit 5.
// - status bit 4 shows receive FIFO not empty.
// - status bit 3 shows live bus reset state.
// - status bit 2 shows bus suspended.
// - host mode, status bit 1 holds minus-line level captured at connect.
// - host mode, status bit 0 shows device attached.
// - device mode, flag bit 7 shows current transfer answered with NAK.
// - bit 6 of flags and transaction status shows toggle matched.
// - flag bits 4..1 set on their events (bit 3 in host mode only), cleared by writing one.
// - flag bit 0 set on attach change (host) or bus reset (device).
// - device mode, setup received sets bit 7 and leaves toggle, token, endpoint, length unchanged.
// - device mode token field: 00 out, 01 frame, 10 in, 11 idle.
// - bits 3..0 hold endpoint in device mode, response PID in host mode.
// - host mode response field holds handshake or data PID returned.
// - receive length register reports bytes received in current transaction.
// - host select bit picks host (1) or device (0) meaning.
// - auto pause with transfer flag set forces NAK or holds host transfers.
module usb_global_irq_status
(
  input  wire logic                                          sys_clk_in,
  input  wire logic                                          reset_n_in,
  input  wire logic [usb_global_irq_status_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]                                    reg_wdata_in,
  input  wire logic                                          reg_write_in,
  input  wire logic                                          reg_read_in,
  input  wire usb_global_irq_status_pkg::engine_status_t     status_in,
  input  wire usb_global_irq_status_pkg::engine_events_t     events_in,
  input  wire usb_global_irq_status_pkg::xfer_info_t         xfer_in,
  output logic [7:0]                                         reg_rdata_out,
  output logic                                               irq_out,
  output logic                                               host_select_out,
  output logic                                               force_nak_out,
  output logic                                               hold_xfer_out
);

  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic [7:0]                                   control;
  logic [7:0]                                   irq_enable;
  logic [7:0]                                   address;
  logic [usb_global_irq_status_pkg::FLAG_W-1:0] flags;
  logic                                         dev_frame_pend;
  logic                                         dev_nak_pend;
  logic [1:0]                                   current_token;
  logic [3:0]                                   current_endpoint;
  logic [3:0]                                   host_response_pid;
  logic                                         toggle_match;
  logic                                         nak_sent;
  logic                                         setup_received;
  logic [7:0]                                   rx_len;
  logic                                         attach_prev;
  logic                                         minus_level_cap;
  logic [7:0]                                   reg_rdata;

  wire wr_control = reg_write_in && hit(reg_addr_in, usb_global_irq_status_pkg::OFF_CONTROL);
  wire wr_irq_en  = reg_write_in && hit(reg_addr_in, usb_global_irq_status_pkg::OFF_IRQ_EN);
  wire wr_address = reg_write_in && hit(reg_addr_in, usb_global_irq_status_pkg::OFF_ADDRESS);
  wire wr_flags   = reg_write_in && hit(reg_addr_in, usb_global_irq_status_pkg::OFF_FLAGS);

  // mode bits
  wire host_select = control[usb_global_irq_status_pkg::BIT_HOST_SELECT];
  wire auto_pause  = control[usb_global_irq_status_pkg::BIT_AUTO_PAUSE];

  // ************************************************************
  // event flags
  // ************************************************************
  // bit 0 is shared: attach change in host mode, bus reset in device mode
  wire [usb_global_irq_status_pkg::FLAG_W-1:0] flag_set =
  {
    events_in.overflow,
    events_in.host_frame_done & host_select,
    events_in.suspend_wake,
    events_in.xfer_done,
    host_select ? events_in.attach_change : events_in.bus_reset
  };
  wire [usb_global_irq_status_pkg::FLAG_W-1:0] flag_clr =
    wr_flags ? reg_wdata_in[usb_global_irq_status_pkg::FLAG_W-1:0] : '0;
  // set wins over a clear in the same cycle so no event is lost
  wire [usb_global_irq_status_pkg::FLAG_W-1:0] next_flags =
    (flags & ~flag_clr) | flag_set;

  wire xfer_clear = flag_clr[usb_global_irq_status_pkg::BIT_XFER_DONE];
  wire dev_frame_clr = wr_flags && reg_wdata_in[usb_global_irq_status_pkg::BIT_DEV_FRAME];
  wire dev_nak_clr   = wr_flags && reg_wdata_in[usb_global_irq_status_pkg::BIT_DEV_NAK];
  wire next_dev_frame_pend =
    (dev_frame_pend & ~dev_frame_clr) | (events_in.frame_rx & ~host_select);
  wire next_dev_nak_pend =
    (dev_nak_pend & ~dev_nak_clr) | (events_in.nak_rx & ~host_select);

  // ************************************************************
  // transaction capture
  // ************************************************************
  // a setup completion must not disturb the token-side fields
  wire capture = events_in.xfer_done & ~events_in.setup_done;
  // first transfer-flag clear retires the token, the next one the setup
  wire token_retire = xfer_clear && !capture;
  wire setup_retire = xfer_clear && current_token == usb_global_irq_status_pkg::TOKEN_IDLE;
  wire next_setup_received =
    (setup_received & ~setup_retire) | (events_in.setup_done & ~host_select);
  wire attach_rise = status_in.device_attached & ~attach_prev;

  // ************************************************************
  // read views
  // ************************************************************
  wire [7:0] pending_vec =
  {
    dev_frame_pend,
    dev_nak_pend,
    1'b0,
    flags
  };
  wire [7:0] misc_view =
  {
    host_select & status_in.frame_pending,
    host_select & status_in.frame_sending,
    status_in.engine_idle,
    status_in.rx_fifo_nonempty,
    status_in.bus_in_reset,
    status_in.bus_suspended,
    host_select & minus_level_cap,
    host_select & status_in.device_attached
  };
  wire [7:0] flags_view =
  {
    ~host_select & nak_sent,
    toggle_match,
    status_in.engine_idle,
    flags
  };
  // low nibble swaps meaning with the mode
  wire [3:0] low_nibble = host_select ? host_response_pid : current_endpoint;
  wire [7:0] xfer_view =
  {
    setup_received,
    toggle_match,
    current_token,
    low_nibble
  };

  wire [7:0] rd_mux =
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_CONTROL) ? control    :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_IRQ_EN)  ? irq_enable :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_ADDRESS) ? address    :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_MISC_ST) ? misc_view  :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_FLAGS)   ? flags_view :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_XFER_ST) ? xfer_view  :
    hit(reg_addr_in, usb_global_irq_status_pkg::OFF_RX_LEN)  ? rx_len     :
    8'h00;
  wire [7:0] next_rdata = reg_read_in ? rd_mux : 8'h00;

  // ************************************************************
  // outputs
  // ************************************************************
  // device-mode enables only count while in device mode
  wire [7:0] mode_gate = host_select ? 8'h3F : 8'hFF;
  assign irq_out         = |(irq_enable & pending_vec & mode_gate);
  assign host_select_out = host_select;
  wire   xfer_unacked    = auto_pause & flags[usb_global_irq_status_pkg::BIT_XFER_DONE];
  assign force_nak_out   = xfer_unacked & ~host_select;
  assign hold_xfer_out   = xfer_unacked & host_select;
  assign reg_rdata_out   = reg_rdata;

  // software registers; reserved enable bit kept at zero
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      control    <= usb_global_irq_status_pkg::CONTROL_RESET;
      irq_enable <= usb_global_irq_status_pkg::IRQ_EN_RESET;
      address    <= usb_global_irq_status_pkg::ADDRESS_RESET;
    end
    else
    begin
      if (wr_control)
        control <= reg_wdata_in & usb_global_irq_status_pkg::CONTROL_MASK;
      if (wr_irq_en)
        irq_enable <= reg_wdata_in & usb_global_irq_status_pkg::IRQ_EN_MASK;
      if (wr_address)
        address <= reg_wdata_in;
    end
  end

  // sticky flags and hidden device-mode pending bits
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flags          <= '0;
      dev_frame_pend <= 1'b0;
      dev_nak_pend   <= 1'b0;
      setup_received <= 1'b0;
    end
    else
    begin
      flags          <= next_flags;
      dev_frame_pend <= next_dev_frame_pend;
      dev_nak_pend   <= next_dev_nak_pend;
      setup_received <= next_setup_received;
    end
  end

  // transaction results, held until the next non-setup completion; the token goes idle on a transfer-flag clear
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      current_token     <= usb_global_irq_status_pkg::TOKEN_IDLE;
      current_endpoint  <= usb_global_irq_status_pkg::NIBBLE_RESET;
      host_response_pid <= usb_global_irq_status_pkg::NIBBLE_RESET;
      toggle_match      <= 1'b0;
      nak_sent          <= 1'b0;
      rx_len            <= usb_global_irq_status_pkg::RX_LEN_RESET;
    end
    else if (capture)
    begin
      current_token     <= xfer_in.current_token;
      current_endpoint  <= xfer_in.current_endpoint;
      host_response_pid <= xfer_in.host_response_pid;
      toggle_match      <= xfer_in.toggle_match;
      nak_sent          <= xfer_in.nak_sent;
      rx_len            <= xfer_in.rx_len;
    end
    else if (token_retire)
      current_token <= usb_global_irq_status_pkg::TOKEN_IDLE;
  end

  // minus-line level caught on the attach edge, read data register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      attach_prev     <= 1'b0;
      minus_level_cap <= 1'b0;
      reg_rdata       <= 8'h00;
    end
    else
    begin
      attach_prev <= status_in.device_attached;
      if (attach_rise)
        minus_level_cap <= status_in.minus_line_level;
      reg_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_xfer_flag_set;
    events_in.xfer_done |=> flags[usb_global_irq_status_pkg::BIT_XFER_DONE];
  endproperty
  a_xfer_flag_set: assert property (p_xfer_flag_set)
    else $error("transfer flag not set after completion");

  property p_w1c;
    wr_flags && reg_wdata_in[usb_global_irq_status_pkg::BIT_OVERFLOW] && !events_in.overflow
      |=> !flags[usb_global_irq_status_pkg::BIT_OVERFLOW];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("overflow flag survived write one");

  property p_irq_or;
    irq_enable[usb_global_irq_status_pkg::BIT_XFER_DONE] &&
      flags[usb_global_irq_status_pkg::BIT_XFER_DONE] |-> irq_out;
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("interrupt line disagrees with flags and enables");

  property p_rsvd_zero;
    wr_irq_en |=> !irq_enable[5] && irq_enable[7:6] == $past(reg_wdata_in[7:6]);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("enable register write wrong");

  property p_setup_keeps;
    events_in.setup_done && !token_retire
      |=> $stable(current_token) && $stable(rx_len) && $stable(toggle_match);
  endproperty
  a_setup_keeps: assert property (p_setup_keeps)
    else $error("setup disturbed transaction fields");

  property p_idle_mirror;
    reg_read_in && hit(reg_addr_in, usb_global_irq_status_pkg::OFF_FLAGS)
      |=> reg_rdata_out[5] == $past(status_in.engine_idle);
  endproperty
  a_idle_mirror: assert property (p_idle_mirror)
    else $error("idle mirror wrong");

  property p_auto_nak;
    auto_pause && !host_select && flags[usb_global_irq_status_pkg::BIT_XFER_DONE]
      |-> force_nak_out && !hold_xfer_out;
  endproperty
  a_auto_nak: assert property (p_auto_nak)
    else $error("auto pause did not force NAK");

  property p_rdata_once;
    !reg_read_in |=> reg_rdata_out == 8'h00;
  endproperty
  a_rdata_once: assert property (p_rdata_once)
    else $error("read data outside the answer cycle");

  property p_token_retire;
    token_retire |=> current_token == usb_global_irq_status_pkg::TOKEN_IDLE;
  endproperty
  a_token_retire: assert property (p_token_retire)
    else $error("token not idle after transfer flag clear");

  property p_rx_len;
    capture |=> rx_len == $past(xfer_in.rx_len);
  endproperty
  a_rx_len: assert property (p_rx_len)
    else $error("receive length not captured");

  property p_address_rw;
    wr_address |=> address == $past(reg_wdata_in);
  endproperty
  a_address_rw: assert property (p_address_rw)
    else $error("address register write lost");

  property p_flag_sticky;
    !wr_flags && flags[usb_global_irq_status_pkg::BIT_SUSPEND]
      |=> flags[usb_global_irq_status_pkg::BIT_SUSPEND];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("suspend flag dropped without a clear");

  property p_busreset_src;
    !host_select && events_in.bus_reset |=> flags[usb_global_irq_status_pkg::BIT_ATTACH];
  endproperty
  a_busreset_src: assert property (p_busreset_src)
    else $error("bus reset flag not set in device mode");

  property p_frame_refused;
    !host_select && !flags[usb_global_irq_status_pkg::BIT_HOST_FRAME]
      |=> !flags[usb_global_irq_status_pkg::BIT_HOST_FRAME];
  endproperty
  a_frame_refused: assert property (p_frame_refused)
    else $error("host frame flag set in device mode");

  property p_minus_cap;
    status_in.device_attached && !attach_prev
      |=> minus_level_cap == $past(status_in.minus_line_level);
  endproperty
  a_minus_cap: assert property (p_minus_cap)
    else $error("minus line level not caught at attach");

  property p_setup_retire;
    xfer_clear && current_token == usb_global_irq_status_pkg::TOKEN_IDLE && !events_in.setup_done
      |=> !setup_received;
  endproperty
  a_setup_retire: assert property (p_setup_retire)
    else $error("setup bit survived the second clear");

  property p_auto_hold;
    auto_pause && host_select && flags[usb_global_irq_status_pkg::BIT_XFER_DONE]
      |-> hold_xfer_out && !force_nak_out;
  endproperty
  a_auto_hold: assert property (p_auto_hold)
    else $error("auto pause did not hold host transfers");

  c_irq: cover property (irq_out);
  c_setup_pair: cover property (setup_received &&
    current_token != usb_global_irq_status_pkg::TOKEN_IDLE ##[1:20] setup_retire);
  c_host_attach: cover property (host_select && attach_rise);
  c_nak_forced: cover property (force_nak_out);

endmodule

// ### shared/usb_global_irq_status_pkg.sv
package usb_global_irq_status_pkg;

  // ************************************************************
  // register map, byte offsets on the 8-bit register port
  // ************************************************************
  localparam int         REG_ADDR_W = 8;
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h02;
  localparam logic [7:0] OFF_ADDRESS = 8'h03;
  localparam logic [7:0] OFF_MISC_ST = 8'h05;
  localparam logic [7:0] OFF_FLAGS   = 8'h06;
  localparam logic [7:0] OFF_XFER_ST = 8'h07;
  localparam logic [7:0] OFF_RX_LEN  = 8'h08;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int BIT_HOST_SELECT = 7;   // control register
  localparam int BIT_AUTO_PAUSE  = 3;   // control register
  localparam int BIT_DEV_FRAME   = 7;   // enable / hidden pending
  localparam int BIT_DEV_NAK     = 6;
  localparam int BIT_OVERFLOW    = 4;
  localparam int BIT_HOST_FRAME  = 3;
  localparam int BIT_SUSPEND     = 2;
  localparam int BIT_XFER_DONE   = 1;
  localparam int BIT_ATTACH      = 0;   // also bus reset in device mode
  localparam int BIT_TOGGLE      = 6;   // flags and transaction status
  localparam int BIT_IDLE        = 5;   // misc status and flags mirror
  localparam int BIT_SETUP       = 7;   // transaction status
  localparam int FLAG_W          = 5;   // sticky flags at bits 4..0

  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_MASK   = 8'h88;
  localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
  localparam logic [7:0] IRQ_EN_MASK    = 8'hDF;  // bit 5 reserved
  localparam logic [7:0] ADDRESS_RESET  = 8'h00;
  localparam logic [7:0] RX_LEN_RESET   = 8'h00;
  localparam logic [3:0] NIBBLE_RESET   = 4'h0;

  // ************************************************************
  // token codes of the current transaction
  // ************************************************************
  localparam logic [1:0] TOKEN_OUT   = 2'h0;
  localparam logic [1:0] TOKEN_FRAME = 2'h1;
  localparam logic [1:0] TOKEN_IN    = 2'h2;
  localparam logic [1:0] TOKEN_IDLE  = 2'h3;

  // live levels from the protocol engine
  typedef struct packed {
    logic frame_pending;
    logic frame_sending;
    logic engine_idle;
    logic rx_fifo_nonempty;
    logic bus_in_reset;
    logic bus_suspended;
    logic minus_line_level;
    logic device_attached;
  } engine_status_t;

  // one-cycle event pulses from the protocol engine
  typedef struct packed {
    logic frame_rx;
    logic nak_rx;
    logic overflow;
    logic host_frame_done;
    logic suspend_wake;
    logic xfer_done;
    logic attach_change;
    logic bus_reset;
    logic setup_done;
  } engine_events_t;

  // transaction results, valid beside xfer_done
  typedef struct packed {
    logic [1:0] current_token;
    logic [3:0] current_endpoint;
    logic [3:0] host_response_pid;
    logic       toggle_match;
    logic       nak_sent;
    logic [7:0] rx_len;
  } xfer_info_t;

endpackage

// ### test/engine_model.sv
`timescale 1ns/1ns

// ************************************************************
// protocol engine stand-in: live levels, event pulses, results
// ************************************************************
module engine_model
(
  input  wire logic                                      sys_clk_in,
  input  wire logic                                      reset_n_in,
  input  wire usb_global_irq_status_pkg::engine_status_t levels_in,
  input  wire usb_global_irq_status_pkg::engine_events_t fire_in,
  input  wire usb_global_irq_status_pkg::xfer_info_t     info_in,
  output usb_global_irq_status_pkg::engine_status_t      status_out,
  output usb_global_irq_status_pkg::engine_events_t      events_out,
  output usb_global_irq_status_pkg::xfer_info_t          xfer_out
);
  // results only hold beside xfer_done; otherwise they flip every cycle
  // so a capture at the wrong cycle shows up as junk
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      status_out <= '0;
      events_out <= '0;
      xfer_out   <= '0;
    end
    else
    begin
      status_out <= levels_in;
      events_out <= fire_in;
      xfer_out   <= fire_in.xfer_done ? info_in : ~xfer_out;
    end
  end
endmodule

// ### test/tb.sv
`timescale 1ns/1ns

module tb;
  // ************************************************************
  // stimulus and observation signals
  // ************************************************************
  logic                                      sys_clk_in;
  logic                                      reset_n_in;
  logic [7:0]                                reg_addr;
  logic [7:0]                                reg_wdata;
  logic                                      reg_write;
  logic                                      reg_read;
  logic [7:0]                                reg_rdata;
  logic                                      irq;
  logic                                      host_select;
  logic                                      force_nak;
  logic                                      hold_xfer;
  usb_global_irq_status_pkg::engine_status_t levels;
  usb_global_irq_status_pkg::engine_events_t fire;
  usb_global_irq_status_pkg::xfer_info_t     info;
  usb_global_irq_status_pkg::engine_status_t status;
  usb_global_irq_status_pkg::engine_events_t events;
  usb_global_irq_status_pkg::xfer_info_t     xfer;
  int                                        errors;
  int                                        tests_run;

  engine_model engine (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .levels_in(levels),
    .fire_in(fire), .info_in(info), .status_out(status), .events_out(events), .xfer_out(xfer));

  usb_global_irq_status uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
    .reg_read_in(reg_read), .status_in(status), .events_in(events), .xfer_in(xfer),
    .reg_rdata_out(reg_rdata), .irq_out(irq), .host_select_out(host_select),
    .force_nak_out(force_nak), .hold_xfer_out(hold_xfer));

  // ************************************************************
  // shared bus and compare tasks
  // ************************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // write lands at the second edge; #1 lets register updates settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk_in);
    reg_write <= 1'b0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge sys_clk_in);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk_in);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask

  // one-cycle engine event, visible in the design two edges later
  task automatic pulse(input logic [8:0] ev, input usb_global_irq_status_pkg::xfer_info_t i);
    @(posedge sys_clk_in);
    fire <= ev;
    info <= i;
    @(posedge sys_clk_in);
    fire <= '0;
    @(posedge sys_clk_in);
    #1;
  endtask

  task automatic set_lv(input logic [7:0] v);
    @(posedge sys_clk_in);
    levels <= v;
    repeat (2) @(posedge sys_clk_in);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h06, 8'h20);
    rd(8'h05, 8'h20);
    rd(8'h07, 8'h30);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_regs;
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'hDF);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'hA5);
    rd(8'h03, 8'hA5);
    wr(8'h03, 8'h5A);
    rd(8'h03, 8'h5A);
    wr(8'h08, 8'h77);
    rd(8'h08, 8'h00);
    rd(8'h01, 8'h00);
    @(posedge sys_clk_in);
    #1;
    chk(reg_rdata, 8'h00);
  endtask

  // minus level must be the one seen at the attach, not the live one
  task automatic t_misc;
    set_lv(8'hFD);
    rd(8'h05, 8'h3C);
    wr(8'h00, 8'h80);
    chk({7'h00, host_select}, 8'h01);
    set_lv(8'h20);
    set_lv(8'hE3);
    rd(8'h05, 8'hE3);
    set_lv(8'hE1);
    rd(8'h05, 8'hE3);
    wr(8'h00, 8'h00);
    rd(8'h05, 8'h20);
    set_lv(8'h20);
  endtask

  // each event: flag set while masked, irq follows enable, write-1 clears
  task automatic t_events;
    logic [8:0] ev  [8] = '{9'h040, 9'h010, 9'h008, 9'h002, 9'h020, 9'h004, 9'h100, 9'h080};
    logic [7:0] ctl [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00};
    int         pos [8] = '{4, 2, 1, 0, 3, 0, 7, 6};
    logic [7:0] seen;
    for (int k = 0; k < 8; k++)
    begin
      seen = (pos[k] < 6) ? (8'h01 << pos[k]) : 8'h00;
      wr(8'h00, ctl[k]);
      wr(8'h02, 8'h00);
      pulse(ev[k], '0);
      chk({7'h00, irq}, 8'h00);
      rd(8'h06, 8'h20 | seen);
      wr(8'h02, 8'h01 << pos[k]);
      chk({7'h00, irq}, 8'h01);
      wr(8'h06, 8'h01 << pos[k]);
      chk({7'h00, irq}, 8'h00);
      rd(8'h06, 8'h20);
    end
    wr(8'h00, 8'h00);
    pulse(9'h020, '0);
    rd(8'h06, 8'h20);
    wr(8'h00, 8'h80);
    pulse(9'h181, '0);
    wr(8'h00, 8'h00);
    wr(8'h02, 8'hC0);
    chk({7'h00, irq}, 8'h00);
    rd(8'h07, 8'h30);
    wr(8'h02, 8'h00);
  endtask

  task automatic t_xfer;
    usb_global_irq_status_pkg::xfer_info_t a;
    a = '{2'h2, 4'h5, 4'hA, 1'b1, 1'b1, 8'h40};
    pulse(9'h008, a);
    rd(8'h07, 8'h65);
    rd(8'h06, 8'hE2);
    rd(8'h08, 8'h40);
    a = '{2'h0, 4'h2, 4'h3, 1'b0, 1'b0, 8'h08};
    pulse(9'h009, a);
    rd(8'h07, 8'hE5);
    rd(8'h08, 8'h40);
    wr(8'h06, 8'h02);
    rd(8'h07, 8'hF5);
    wr(8'h06, 8'h02);
    rd(8'h07, 8'h75);
    wr(8'h00, 8'h80);
    a = '{2'h2, 4'h3, 4'h2, 1'b1, 1'b0, 8'h10};
    pulse(9'h008, a);
    rd(8'h07, 8'h02, 8'h0F);
    rd(8'h06, 8'h62);
  endtask

  task automatic t_pause;
    wr(8'h06, 8'hFF);
    wr(8'h00, 8'h08);
    chk({6'h00, force_nak, hold_xfer}, 8'h00);
    pulse(9'h008, '0);
    chk({6'h00, force_nak, hold_xfer}, 8'h02);
    wr(8'h00, 8'h88);
    chk({6'h00, force_nak, hold_xfer}, 8'h01);
    wr(8'h06, 8'h02);
    chk({6'h00, force_nak, hold_xfer}, 8'h00);
  endtask

  task automatic give_verdict;
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog and main sequence
  // ************************************************************
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // the full run needs well under 2000 cycles
  initial
  begin
    #20000;
    errors++;
    give_verdict();
  end

  initial
  begin
    errors     = 0;
    tests_run  = 0;
    reset_n_in = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_write  = 1'b0;
    reg_read   = 1'b0;
    levels     = 8'h20;
    fire       = '0;
    info       = '0;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_regs();
    t_misc();
    t_events();
    t_xfer();
    t_pause();
    give_verdict();
  end
endmodule
